// ==== bench/pin_partner.sv ====
// partner: external pin wiring, outside drivers and pulldown loading
`timescale 1ns/1ps
module pin_partner
  import port_b_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic [PORT_WIDTH-1:0] pin_o,
  input  wire logic [PORT_WIDTH-1:0] pin_oe_n_o,
  input  wire logic [PORT_WIDTH-1:0] pulldown_on_o,
  input  wire logic [PORT_WIDTH-1:0] ext_val_i,
  input  wire logic [PORT_WIDTH-1:0] ext_en_i,
  output logic      [PORT_WIDTH-1:0] level_o
);
  // ****************************************************************
  // pin level
  // ****************************************************************
  logic [PORT_WIDTH-1:0] last_reg;

  always_ff @(posedge clk_sys_i) begin
    last_reg <= level_o;
  end

  // floating pin toggles so a stale value never passes for a real one
  always_comb begin
    for (int i = 0; i < PORT_WIDTH; i++) begin
      if (!pin_oe_n_o[i]) level_o[i] = pin_o[i];
      else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
      else if (pulldown_on_o[i]) level_o[i] = 1'b0;
      else level_o[i] = ~last_reg[i];
    end
  end
endmodule : pin_partner

// ==== bench/port_b_gpio_bench.sv ====
// testbench: port b gpio against a behavioural model
`timescale 1ns/1ps
module port_b_gpio_bench;
  import port_b_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic                   clk_sys_i = 1'b0;
  logic                   rst_i     = 1'b1;
  logic                   ce_i      = 1'b1;
  bus_req_type            bus_r     = '0;
  share_in_type           share_r   = '0;
  logic [PORT_WIDTH-1:0]  ext_val   = 8'h00;
  logic [PORT_WIDTH-1:0]  ext_en    = 8'hff;
  logic [PORT_WIDTH-1:0]  rdata_o, pin_o, pin_oe_n_o, pulldown_on_o, pin_i;
  logic [SHARED_PINS-1:0] shared_in_o;
  logic [31:0]            seed      = 32'h0000_5b4a;
  logic [PORT_WIDTH-1:0]  dir_m, inh_m, data_m, drv_m, pd_m, lvl_m, v;
  logic [4:0]             sh;
  int                     num_errors = 0;
  int                     checked    = 0;
  int                     cycles     = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  port_b_gpio uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .bus_i(bus_r),
    .rdata_o(rdata_o), .share_i(share_r), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n_o(pin_oe_n_o), .pulldown_on_o(pulldown_on_o), .shared_in_o(shared_in_o));

  pin_partner pins (.clk_sys_i(clk_sys_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
    .pulldown_on_o(pulldown_on_o), .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(pin_i));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] rnd();
    seed = seed[0] ? ((seed >> 1) ^ 32'h8020_0003) : (seed >> 1);
    return seed[7:0];
  endfunction : rnd

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    bus_r.addr  <= a;
    bus_r.wdata <= d;
    bus_r.wr    <= 1'b1;
    @(posedge clk_sys_i);
    bus_r.wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    bus_r.addr <= a;
    bus_r.rd   <= 1'b1;
    @(posedge clk_sys_i);
    bus_r.rd   <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rd

  // write then read with no gap between the two strobes
  task automatic wr_rd(input logic [1:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge clk_sys_i);
    bus_r.addr  <= a;
    bus_r.wdata <= d;
    bus_r.wr    <= 1'b1;
    @(posedge clk_sys_i);
    bus_r.wr    <= 1'b0;
    bus_r.rd    <= 1'b1;
    @(posedge clk_sys_i);
    bus_r.rd    <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : wr_rd

  // model: the drive, pulldown and pin level that the port must show
  task automatic model();
    drv_m    = data_m;
    drv_m[4] = data_m[4] | sh[4] | (sh[1] & sh[2] & sh[3]);
    pd_m     = sh[0] ? 8'h00 : (~inh_m & ~dir_m);
    lvl_m    = (dir_m & drv_m) | (~dir_m & ext_en & ext_val);
  endtask : model

  task automatic do_reset();
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    dir_m = DIRECTION_RESET;
    inh_m = PULLDOWN_INHIBIT_RESET;
    model();
    #1 chk(pin_oe_n_o, 8'hff);
    chk(pulldown_on_o, pd_m);
    rd(OFFSET_DIRECTION, 8'h00);
  endtask : do_reset

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    sh = 5'h00;
    do_reset();
    for (int n = 0; n < 64; n++) begin
      v = rnd(); wr(OFFSET_DATA, v); data_m = v;
      v = rnd(); wr_rd(OFFSET_DIRECTION, v, v); dir_m = v;
      v = rnd(); wr(OFFSET_PULLDOWN_INHIBIT, v); inh_m = v;
      wr(2'h3, rnd());
      v = rnd(); sh = v[4:0];
      share_r <= share_in_type'(sh);
      model();
      // pins without a pulldown are always driven from outside
      ext_val <= rnd();
      ext_en  <= rnd() | ~pd_m;
      repeat (6) @(posedge clk_sys_i);
      model();
      #1 chk(pin_oe_n_o, ~dir_m);
      chk(pulldown_on_o, pd_m);
      chk(pin_o, dir_m & drv_m);
      chk({3'b000, shared_in_o}, {3'b000, lvl_m[4:0]});
      rd(OFFSET_DATA, (dir_m & drv_m) | (~dir_m & lvl_m));
      rd(OFFSET_DIRECTION, dir_m);
      rd(OFFSET_PULLDOWN_INHIBIT, PULLDOWN_INHIBIT_READ);
      rd(2'h3, UNMAPPED_READ);
      if (n == 40) begin
        // strobe while frozen must leave the direction alone
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        wr(OFFSET_DIRECTION, ~dir_m);
        @(posedge clk_sys_i);
        ce_i <= 1'b1;
        rd(OFFSET_DIRECTION, dir_m);
        do_reset();
      end
    end
    report_and_stop();
  end
endmodule : port_b_gpio_bench

// ==== design/pin_sync.sv ====
// module: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o
);
  import port_b_pkg::*;

  // ****************************************************************
  // stages
  // ****************************************************************
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] level_next;

  // stage1 feeds stage2 only; the filter looks at stages 2 and 3
  assign agree      = ~(stage2_reg ^ stage3_reg);
  assign level_next = (agree & stage3_reg) | (~agree & level_reg);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stage1_reg <= WIDTH'(SYNC_RESET);
      stage2_reg <= WIDTH'(SYNC_RESET);
      stage3_reg <= WIDTH'(SYNC_RESET);
      level_reg  <= WIDTH'(SYNC_RESET);
    end else if (ce_i) begin
      stage1_reg <= async_i;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      level_reg  <= level_next;
    end
  end

  assign level_o = level_reg;

endmodule : pin_sync

// ==== design/port_b_gpio.sv ====
// module: port b gpio with shared analog, timer and comparator pins
`timescale 1ns/1ps
module port_b_gpio #(
  parameter int PORT_W = port_b_pkg::PORT_WIDTH
) (
  input  wire logic                             clk_sys_i,
  input  wire logic                             rst_i,
  input  wire logic                             ce_i,
  input  wire port_b_pkg::bus_req_type          bus_i,
  output logic      [port_b_pkg::PORT_WIDTH-1:0] rdata_o,
  input  wire port_b_pkg::share_in_type         share_i,
  input  wire logic [port_b_pkg::PORT_WIDTH-1:0] pin_i,
  output logic      [port_b_pkg::PORT_WIDTH-1:0] pin_o,
  output logic      [port_b_pkg::PORT_WIDTH-1:0] pin_oe_n_o,
  output logic      [port_b_pkg::PORT_WIDTH-1:0] pulldown_on_o,
  output logic      [port_b_pkg::SHARED_PINS-1:0] shared_in_o
);
  import port_b_pkg::*;

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [PORT_WIDTH-1:0] data_reg;
  logic [PORT_WIDTH-1:0] data_next;
  logic [PORT_WIDTH-1:0] direction_reg;
  logic [PORT_WIDTH-1:0] direction_next;
  logic [PORT_WIDTH-1:0] inhibit_reg;
  logic [PORT_WIDTH-1:0] inhibit_next;
  logic [PORT_WIDTH-1:0] rdata_reg;
  logic [PORT_WIDTH-1:0] rdata_next;

  // ****************************************************************
  // decode
  // ****************************************************************
  wire hit_data      = (bus_i.addr == OFFSET_DATA);
  wire hit_direction = (bus_i.addr == OFFSET_DIRECTION);
  wire hit_inhibit   = (bus_i.addr == OFFSET_PULLDOWN_INHIBIT);
  wire wr_data       = bus_i.wr & hit_data;
  wire wr_direction  = bus_i.wr & hit_direction;
  wire wr_inhibit    = bus_i.wr & hit_inhibit;

  // ****************************************************************
  // pin sampling
  // ****************************************************************
  logic [PORT_WIDTH-1:0] pin_sample;

  // pins are asynchronous to the bus clock
  pin_sync #(
    .WIDTH (PORT_WIDTH)
  ) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .async_i   (pin_i),
    .level_o   (pin_sample)
  );

  // shared modules see the digital sample, pulldown loading is physical
  assign shared_in_o = pin_sample[SHARED_PINS-1:0];

  // ****************************************************************
  // pin 4 source mixing
  // ****************************************************************
  wire cmp_gated  = share_i.comparator_output_select
                  & share_i.comparator1_output_enable
                  & share_i.comparator1_output;
  wire pin4_drive = data_reg[PIN4_INDEX]
                  | share_i.timer_output_level
                  | cmp_gated;

  // ****************************************************************
  // per-pin output, pulldown and read selection
  // ****************************************************************
  logic [PORT_WIDTH-1:0] out_value;
  logic [PORT_WIDTH-1:0] read_value;

  generate
    for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_bit
      if (i == PIN4_INDEX) begin : g_pin4
        assign out_value[i] = pin4_drive;
      end else begin : g_plain
        assign out_value[i] = data_reg[i];
      end
      // output mode reads the driven value, input mode the sampled level
      assign read_value[i] = direction_reg[i] ? out_value[i] : pin_sample[i];
    end
  endgenerate

  // undriven pins output zero so the latch is never seen while off
  assign pin_o      = out_value & direction_reg;
  assign pin_oe_n_o = ~direction_reg;

  // pulldown only for inputs, never when inhibited or globally off
  assign pulldown_on_o = share_i.global_pulldown_disable
                       ? {PORT_WIDTH{1'b0}}
                       : (~inhibit_reg & ~direction_reg);

  // ****************************************************************
  // register writes
  // ****************************************************************
  assign data_next      = wr_data ? bus_i.wdata : data_reg;
  assign direction_next = wr_direction ? bus_i.wdata : direction_reg;
  assign inhibit_next   = wr_inhibit ? bus_i.wdata : inhibit_reg;

  // ****************************************************************
  // read path
  // ****************************************************************
  // inhibit reads back a fixed zero: read-modify-write would corrupt it
  wire [PORT_WIDTH-1:0] read_mux = hit_data      ? read_value :
                                   hit_direction ? direction_reg :
                                   hit_inhibit   ? PULLDOWN_INHIBIT_READ :
                                   UNMAPPED_READ;

  // read data fall back to zero so a stale value never looks fresh
  assign rdata_next = bus_i.rd ? read_mux : RDATA_IDLE;

  // ****************************************************************
  // flip-flops
  // ****************************************************************
  // data latch keeps its value through reset
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      data_reg <= data_next;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      direction_reg <= DIRECTION_RESET;
      inhibit_reg   <= PULLDOWN_INHIBIT_RESET;
      rdata_reg     <= RDATA_IDLE;
    end else if (ce_i) begin
      direction_reg <= direction_next;
      inhibit_reg   <= inhibit_next;
      rdata_reg     <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  a_reset_clears_config: assert property (
    $past(rst_i) |-> (direction_reg == 8'h00) && (inhibit_reg == 8'h00)
                     && (pin_oe_n_o == 8'hFF))
    else $error("config not cleared after reset");

  a_buffer_follows_dir: assert property (
    ce_i && wr_direction |=> (pin_oe_n_o == ~$past(bus_i.wdata)))
    else $error("output enable does not follow direction write");

  a_output_no_pulldown: assert property (
    (pulldown_on_o & direction_reg) == 8'h00)
    else $error("pulldown active on an output pin");

  a_inhibit_kills_pull: assert property (
    ce_i && wr_inhibit ##1 !(ce_i && (wr_inhibit || wr_direction))
      |=> ((pulldown_on_o & $past(inhibit_reg)) == 8'h00))
    else $error("inhibited pulldown still on");

  a_global_pull_off: assert property (
    share_i.global_pulldown_disable |-> (pulldown_on_o == 8'h00))
    else $error("pulldown on while globally disabled");

  a_input_pull_on: assert property (
    !share_i.global_pulldown_disable && !direction_reg[0] && !inhibit_reg[0]
      |-> pulldown_on_o[0])
    else $error("input pulldown missing");

  a_inhibit_reads_zero: assert property (
    ce_i && bus_i.rd && hit_inhibit |=> (rdata_o == PULLDOWN_INHIBIT_READ))
    else $error("inhibit register read not zero");

  a_rdata_idle_zero: assert property (
    ce_i && !bus_i.rd |=> (rdata_o == RDATA_IDLE))
    else $error("read data did not return to idle");

  a_inhibit_read_keeps: assert property (
    bus_i.rd && hit_inhibit && !bus_i.wr |=> $stable(inhibit_reg))
    else $error("inhibit read disturbed stored bits");

  a_input_reads_pin: assert property (
    ce_i && bus_i.rd && hit_data && !direction_reg[PIN4_INDEX]
      |=> rdata_o[PIN4_INDEX] == $past(pin_sample[PIN4_INDEX]))
    else $error("input read not the pin sample");

  a_output_reads_latch: assert property (
    ce_i && bus_i.rd && hit_data && direction_reg[0]
      |=> rdata_o[0] == $past(data_reg[0]))
    else $error("output read not the latch");

  a_latch_always_wr: assert property (
    ce_i && wr_data |=> data_reg == $past(bus_i.wdata))
    else $error("data latch write lost");

  a_dir_readback: assert property (
    ce_i && wr_direction ##1 ce_i && bus_i.rd && hit_direction
      |=> rdata_o == $past(bus_i.wdata, 2))
    else $error("direction readback mismatch");

  a_shared_follow: assert property (
    (ce_i && $stable(pin_i[0]))[*5] |-> shared_in_o[0] == pin_i[0])
    else $error("shared input does not follow a quiet pin");

  a_pin4_or_sources: assert property (
    direction_reg[PIN4_INDEX] |-> pin_o[PIN4_INDEX] ==
      (data_reg[PIN4_INDEX] | share_i.timer_output_level
       | (share_i.comparator_output_select & share_i.comparator1_output_enable
          & share_i.comparator1_output)))
    else $error("pin 4 drive not the OR of its sources");

  a_timer_drives_high: assert property (
    ce_i && direction_reg[PIN4_INDEX] && share_i.timer_output_level && bus_i.rd && hit_data
      |-> pin_o[PIN4_INDEX] ##1 rdata_o[PIN4_INDEX])
    else $error("timer level does not force pin 4 high");

  a_cmp_needs_select: assert property (
    !share_i.comparator_output_select && direction_reg[PIN4_INDEX]
      |-> pin_o[PIN4_INDEX] == (data_reg[PIN4_INDEX] | share_i.timer_output_level))
    else $error("comparator leaked onto pin 4");

  a_pin4_input_pull: assert property (
    !direction_reg[PIN4_INDEX] |-> pin_oe_n_o[PIN4_INDEX] && !pin_o[PIN4_INDEX]
      && (pulldown_on_o[PIN4_INDEX] ==
          !(inhibit_reg[PIN4_INDEX] | share_i.global_pulldown_disable)))
    else $error("pin 4 input mode broken");

  // ****************************************************************
  // register bus checks
  // ****************************************************************
  a_dir_write_lands: assert property (
    ce_i && wr_direction |=> direction_reg == $past(bus_i.wdata))
    else $error("direction write lost");

  a_dir_read_stored: assert property (
    ce_i && bus_i.rd && hit_direction |=> rdata_o == $past(direction_reg))
    else $error("direction read not the stored value");

  a_inhibit_write_lands: assert property (
    ce_i && wr_inhibit |=> inhibit_reg == $past(bus_i.wdata))
    else $error("pulldown inhibit write lost");

  a_unmapped_wr_ignored: assert property (
    ce_i && bus_i.wr && !hit_data && !hit_direction && !hit_inhibit
      |=> $stable(direction_reg) && $stable(inhibit_reg))
    else $error("unmapped write changed a register");

  a_freeze_holds_state: assert property (
    !ce_i |=> $stable(direction_reg) && $stable(inhibit_reg) && $stable(rdata_o))
    else $error("state moved while clock enable low");

  a_out_read_pin7: assert property (
    ce_i && bus_i.rd && hit_data && direction_reg[PORT_WIDTH-1]
      |=> rdata_o[PORT_WIDTH-1] == $past(data_reg[PORT_WIDTH-1]))
    else $error("output read of pin 7 not the latch");

  a_input_read_bit0: assert property (
    ce_i && bus_i.rd && hit_data && !direction_reg[0]
      |=> rdata_o[0] == $past(pin_sample[0]))
    else $error("input read of pin 0 not the pin sample");

  // ****************************************************************
  // pin checks
  // ****************************************************************
  a_reset_idles_read: assert property (
    $past(rst_i) |-> (rdata_o == RDATA_IDLE) && (pin_o == 8'h00))
    else $error("read data or pin drive not idle after reset");

  a_pulldown_on_reset: assert property (
    $past(rst_i) && !share_i.global_pulldown_disable |-> (pulldown_on_o == 8'hFF))
    else $error("pulldowns not all on after reset");

  a_input_pin_quiet: assert property (
    (pin_o & ~direction_reg) == 8'h00)
    else $error("input pin still driven");

  a_pin4_out_buffer: assert property (
    direction_reg[PIN4_INDEX] |-> !pin_oe_n_o[PIN4_INDEX] && !pulldown_on_o[PIN4_INDEX])
    else $error("pin 4 output buffer or pulldown wrong");

  a_cmp_drives_high: assert property (
    direction_reg[PIN4_INDEX] && share_i.comparator_output_select
      && share_i.comparator1_output_enable && share_i.comparator1_output
      |-> pin_o[PIN4_INDEX])
    else $error("selected comparator does not drive pin 4 high");

  a_cmp_read_high: assert property (
    ce_i && bus_i.rd && hit_data && direction_reg[PIN4_INDEX] && cmp_gated
      |=> rdata_o[PIN4_INDEX])
    else $error("pin 4 read not high under the comparator");

  // the level follows a pin that has stayed quiet for four samples; the check waits five
  a_sample_tracks_pin: assert property (
    (ce_i && $stable(pin_i[PORT_WIDTH-1]))[*5]
      |-> pin_sample[PORT_WIDTH-1] == pin_i[PORT_WIDTH-1])
    else $error("pin 7 sample does not follow a quiet pin");

  // ****************************************************************
  // covers
  // ****************************************************************
  c_cmp_on_pin4: cover property (
    direction_reg[PIN4_INDEX] && cmp_gated && !data_reg[PIN4_INDEX]
      && !share_i.timer_output_level);

  c_input_read: cover property (
    ce_i && bus_i.rd && hit_data && (direction_reg == 8'h00) ##1 (rdata_o != 8'h00));

  c_global_off: cover property (
    share_i.global_pulldown_disable && (inhibit_reg == 8'h00) && (direction_reg == 8'h00));

  c_dir_write_read: cover property (
    ce_i && wr_direction ##1 ce_i && bus_i.rd && hit_direction);

  c_timer_setup: cover property (
    direction_reg[PIN4_INDEX] && !data_reg[PIN4_INDEX] && !share_i.comparator_output_select
      && share_i.timer_output_level && pin_o[PIN4_INDEX]);

endmodule : port_b_gpio

// ==== design/port_b_pkg.sv ====
// package: constants, register map and carriers for the port b gpio block
package port_b_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 2;
  localparam int SHARED_PINS = 5;
  localparam int PIN4_INDEX = 4;
  localparam int SYNC_STAGES = 3;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [ADDR_WIDTH-1:0] OFFSET_DATA = 2'h0;
  localparam logic [ADDR_WIDTH-1:0] OFFSET_DIRECTION = 2'h1;
  localparam logic [ADDR_WIDTH-1:0] OFFSET_PULLDOWN_INHIBIT = 2'h2;

  // ****************************************************************
  // reset and fixed read values
  // ****************************************************************
  localparam logic [PORT_WIDTH-1:0] DIRECTION_RESET = 8'h00;
  localparam logic [PORT_WIDTH-1:0] PULLDOWN_INHIBIT_RESET = 8'h00;
  localparam logic [PORT_WIDTH-1:0] PULLDOWN_INHIBIT_READ = 8'h00;
  localparam logic [PORT_WIDTH-1:0] UNMAPPED_READ = 8'h00;
  localparam logic [PORT_WIDTH-1:0] RDATA_IDLE = 8'h00;
  localparam logic [PORT_WIDTH-1:0] SYNC_RESET = 8'h00;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [PORT_WIDTH-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } bus_req_type;

  typedef struct packed {
    logic timer_output_level;
    logic comparator1_output;
    logic comparator1_output_enable;
    logic comparator_output_select;
    logic global_pulldown_disable;
  } share_in_type;

endpackage : port_b_pkg
